// ### core/sgps_defs.vh
// constants for the servo gain panel store
// assumes one 100 mhz system clock; panel buttons arrive already debounced
`ifndef SGPS_DEFS_VH
`define SGPS_DEFS_VH
// Contract
// - each of the four gains is held as a setting from 0 to 100.
// - each gain has its own maximum and the applied gain is the setting scaled by it.
// - while a select button is held the display shows that gain as 0 to 99.
// - with a select held, each up press adds one and each down press takes one.
// - a held up or down button keeps stepping until it is released.
// - on release of up or down the displayed value becomes the applied gain.
// - changes stay in working storage until a save command writes memory.
// - reset or soft reset reloads every gain from non-volatile memory.
// - pressing proportional and integral select together loads factory gains.
// - pressing all four select buttons together saves the gains.
// - the factory restore command has the same effect as the button pair.
// - four set-gain commands each write their own gain.
// - four set-maximum commands each write their own maximum.
// - every panel adjustment can be made by serial command with the same result.
`define SGPS_GAIN_MAX_SETTING 7'h64
`define SGPS_DISP_TOP 7'h63
`define SGPS_IDX_P 0
`define SGPS_IDX_I 1
`define SGPS_IDX_D 2
`define SGPS_IDX_V 3
`define SGPS_FACT_GAIN 7'h32
`define SGPS_FACT_MAX 16'h1000
`define SGPS_REPEAT_NS 100000000
`define SGPS_CLK_NS 10
`define SGPS_REPEAT_CYC (`SGPS_REPEAT_NS / `SGPS_CLK_NS)
`endif

// ### core/sgps_store.v
// servo gain panel store: four gains, their maximums, panel and serial access
// assumes buttons are clean synchronous levels and the nv memory is a simple
// word store supplied from outside with a write strobe and two read words
//
// overview of the data path:
//   - working storage is one seven-bit setting and one maximum per gain;
//     index 0 is proportional, 1 integral, 2 derivative, 3 velocity
//   - the applied loop gain is the setting scaled against its maximum,
//     so a setting of 100 hands the full maximum to the servo loop
//   - the panel path copies the chosen gain into a work value while a
//     single select button is held; up and down step that work value
//   - the work value only becomes the setting when up or down is let go,
//     which keeps a half-finished adjustment away from the servo loop
//   - serial set commands write a setting or a maximum directly
//   - nothing reaches the nv memory except through a save request
//
// reset and reload:
//   - the async reset is released through two flops, and everything else
//     is reset by that synchronised copy to avoid a ragged release
//   - the first cycle after release is a load cycle that copies the nv
//     words into working storage; soft reset re-enters that cycle
//   - a save asked for during a load cycle is dropped on purpose, since
//     working storage does not yet hold anything worth keeping
//
// precedence inside one cycle, highest first:
//   - load cycle, then factory restore, then serial set, then panel release
//   - a set-maximum command is independent of the setting writes
//
// limitations:
//   - buttons must already be debounced; a bouncing up button would be
//     seen as several presses and step more than once
//   - the auto-repeat interval is fixed by a parameter, with no speed-up
//     after a long hold
//
`include "sgps_defs.vh"
module sgps_store #(
   parameter MAX_W = 16,
   parameter REPEAT_CYC = `SGPS_REPEAT_CYC
) (
   input wire clk_sys_in,
   input wire rstn_in,
   input wire btn_p_in,
   input wire btn_i_in,
   input wire btn_d_in,
   input wire btn_v_in,
   input wire btn_up_in,
   input wire btn_down_in,
   input wire soft_reset_cmd_in,
   input wire factory_restore_cmd_in,
   input wire save_nonvolatile_cmd_in,
   input wire set_prop_gain_cmd_in,
   input wire set_integ_gain_cmd_in,
   input wire set_deriv_gain_cmd_in,
   input wire set_vel_gain_cmd_in,
   input wire set_prop_max_cmd_in,
   input wire set_integ_max_cmd_in,
   input wire set_deriv_max_cmd_in,
   input wire set_vel_max_cmd_in,
   input wire [6:0] cmd_gain_in,
   input wire [MAX_W-1:0] cmd_max_in,
   input wire [27:0] nv_gain_in,
   input wire [4*MAX_W-1:0] nv_max_in,
   output reg nv_write_out,
   output reg [27:0] nv_gain_out,
   output reg [4*MAX_W-1:0] nv_max_out,
   output reg [6:0] display_out,
   output reg display_on_out,
   output reg [27:0] gain_setting_out,
   output reg [4*MAX_W-1:0] gain_max_out,
   output reg [4*MAX_W-1:0] four_gain_loop_out
);

   // one-hot states: load copies nv words, run waits, hold edits one gain
   localparam ST_LOAD = 3'b001;
   localparam ST_RUN = 3'b010;
   localparam ST_HOLD = 3'b100;

   reg rst_meta_q;
   reg rst_sync_q;
   reg [2:0] state_q;
   reg [6:0] gain_q [0:3];
   reg [MAX_W-1:0] max_q [0:3];
   reg [6:0] work_q;
   reg [1:0] sel_q;
   reg up_prev_q;
   reg down_prev_q;
   reg [31:0] rep_q;
   reg combo_prev_q;
   reg save_prev_q;

   // button decode: a single select enters hold, two combos act on the
   // press edge only so a held combo does not repeat its action
   wire [3:0] sel_btn = {btn_v_in, btn_d_in, btn_i_in, btn_p_in};
   wire one_sel = (sel_btn == 4'h1) | (sel_btn == 4'h2) | (sel_btn == 4'h4) | (sel_btn == 4'h8);
   wire [1:0] sel_idx = btn_i_in ? 2'h1 : btn_d_in ? 2'h2 : btn_v_in ? 2'h3 : 2'h0;
   wire save_combo = (sel_btn == 4'hf);
   wire fact_combo = btn_p_in & btn_i_in & ~btn_d_in & ~btn_v_in;
   wire fact_go = (fact_combo & ~combo_prev_q) | factory_restore_cmd_in;
   wire save_go = (save_combo & ~save_prev_q) | save_nonvolatile_cmd_in;
   // up and down together cancel; neither steps while both are held
   wire stepping = btn_up_in ^ btn_down_in;
   wire step_now = (btn_up_in & ~up_prev_q) | (btn_down_in & ~down_prev_q)
                   | (rep_q == REPEAT_CYC - 1);
   // release of either direction commits the work value
   wire released = (up_prev_q & ~btn_up_in) | (down_prev_q & ~btn_down_in);
   // serial command strobes gathered by gain index
   wire [3:0] gcmd = {set_vel_gain_cmd_in, set_deriv_gain_cmd_in,
                      set_integ_gain_cmd_in, set_prop_gain_cmd_in};
   wire [3:0] mcmd = {set_vel_max_cmd_in, set_deriv_max_cmd_in,
                      set_integ_max_cmd_in, set_prop_max_cmd_in};
   // serial writes clip to the legal setting range
   wire [6:0] cmd_gain_clip = (cmd_gain_in > `SGPS_GAIN_MAX_SETTING) ?
                              `SGPS_GAIN_MAX_SETTING : cmd_gain_in;

   // reset release through two flops
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // panel and command state machine
   always @(posedge clk_sys_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         state_q <= ST_LOAD;
         work_q <= 7'h00;
         sel_q <= 2'h0;
         up_prev_q <= 1'b0;
         down_prev_q <= 1'b0;
         rep_q <= 32'h0;
         combo_prev_q <= 1'b0;
         save_prev_q <= 1'b0;
      end else begin
         up_prev_q <= btn_up_in;
         down_prev_q <= btn_down_in;
         combo_prev_q <= fact_combo;
         save_prev_q <= save_combo;
         // auto-repeat counter restarts on each step so hold rate is steady
         if (state_q == ST_HOLD && stepping && !step_now)
            rep_q <= rep_q + 32'h1;
         else
            rep_q <= 32'h0;
         case (state_q)
            ST_LOAD: state_q <= soft_reset_cmd_in ? ST_LOAD : ST_RUN;
            ST_RUN: begin
               if (soft_reset_cmd_in)
                  state_q <= ST_LOAD;
               else if (one_sel) begin
                  state_q <= ST_HOLD;
                  sel_q <= sel_idx;
                  // a stored 100 shows as 99 so the two digits stay valid
                  work_q <= (gain_q[sel_idx] > `SGPS_DISP_TOP) ?
                            `SGPS_DISP_TOP : gain_q[sel_idx];
               end
            end
            ST_HOLD: begin
               if (soft_reset_cmd_in)
                  state_q <= ST_LOAD;
               else if (!one_sel || sel_idx != sel_q)
                  state_q <= ST_RUN;
               else if (stepping && step_now) begin
                  if (btn_up_in && work_q < `SGPS_DISP_TOP)
                     work_q <= work_q + 7'h01;
                  else if (btn_down_in && work_q != 7'h00)
                     work_q <= work_q - 7'h01;
               end
            end
            default: state_q <= ST_LOAD;
         endcase
      end
   end

   // per-gain storage: load, factory, serial, panel release
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_gain
         always @(posedge clk_sys_in or negedge rst_sync_q) begin
            if (!rst_sync_q) begin
               gain_q[g] <= `SGPS_FACT_GAIN;
               max_q[g] <= `SGPS_FACT_MAX;
            end else if (state_q == ST_LOAD) begin
               // unsaved edits are dropped here
               gain_q[g] <= nv_gain_in[7*g +: 7];
               max_q[g] <= nv_max_in[MAX_W*g +: MAX_W];
            end else if (fact_go) begin
               gain_q[g] <= `SGPS_FACT_GAIN;
               max_q[g] <= `SGPS_FACT_MAX;
            end else begin
               if (gcmd[g])
                  gain_q[g] <= cmd_gain_clip;
               else if (state_q == ST_HOLD && sel_q == g && released)
                  gain_q[g] <= work_q;
               if (mcmd[g])
                  max_q[g] <= cmd_max_in;
            end
         end
         // applied gain = setting * max / 100; the product needs seven more
         // bits than a maximum, or a setting of 100 would wrap the result
         wire [MAX_W+6:0] prod_w = gain_q[g] * max_q[g];
         // the quotient exceeds the maximum only for an nv-loaded setting above 100; otherwise the slice is exact
         wire [MAX_W+6:0] quot_w = prod_w / `SGPS_GAIN_MAX_SETTING;
         always @(posedge clk_sys_in or negedge rst_sync_q) begin
            if (!rst_sync_q)
               four_gain_loop_out[MAX_W*g +: MAX_W] <= {MAX_W{1'b0}};
            else
               four_gain_loop_out[MAX_W*g +: MAX_W] <= quot_w[MAX_W-1:0];
         end
         // working values are shown as they are, with no extra register
         always @* begin
            gain_setting_out[7*g +: 7] = gain_q[g];
            gain_max_out[MAX_W*g +: MAX_W] = max_q[g];
         end
      end
   endgenerate

   // nv write port and display; only save touches nv memory
   always @(posedge clk_sys_in or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         nv_write_out <= 1'b0;
         nv_gain_out <= 28'h0;
         nv_max_out <= {4*MAX_W{1'b0}};
         display_out <= 7'h00;
         display_on_out <= 1'b0;
      end else begin
         // one-cycle strobe with the data beside it, so the memory sees a
         // single coherent snapshot of all four gains and maximums
         nv_write_out <= save_go && state_q != ST_LOAD;
         if (save_go && state_q != ST_LOAD) begin
            nv_gain_out <= gain_setting_out;
            nv_max_out <= gain_max_out;
         end
         // display is blank outside hold so stale digits never linger
         display_on_out <= (state_q == ST_HOLD);
         display_out <= (state_q == ST_HOLD) ? work_q : 7'h00;
      end
   end

endmodule // sgps_store

// ### tb/sgps_nv_model.sv
// non-volatile word store standing beside the gain store
// assumes the store registers its write strobe and data together
module sgps_nv_model (
   input wire clk_sys_in,
   input wire nv_write_in,
   input wire [27:0] gain_in,
   input wire [63:0] max_in,
   output reg [27:0] gain_out,
   output reg [63:0] max_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // contents outlive every reset of the store, as real memory does
   initial begin
      gain_out = {7'h28, 7'h1e, 7'h14, 7'h0a};
      max_out = {4{16'h0200}};
   end
   // only the strobe may change the memory
   always @(posedge clk_sys_in)
      if (nv_write_in) begin
         gain_out <= gain_in;
         max_out <= max_in;
      end
endmodule // sgps_nv_model

// ### tb/sgps_store_checker.sv
// assertions on the gain store ports
// assumes bind into the store from the bench top
`include "sgps_defs.vh"
module sgps_store_checker #(parameter MAX_W = 16) (
   input wire clk_sys_in,
   input wire rstn_in,
   input wire factory_restore_cmd_in,
   input wire save_nonvolatile_cmd_in,
   input wire set_prop_gain_cmd_in,
   input wire set_vel_max_cmd_in,
   input wire [6:0] cmd_gain_in,
   input wire [MAX_W-1:0] cmd_max_in,
   input wire nv_write_out,
   input wire [27:0] nv_gain_out,
   input wire [6:0] display_out,
   input wire display_on_out,
   input wire [27:0] gain_setting_out,
   input wire [4*MAX_W-1:0] gain_max_out,
   input wire [4*MAX_W-1:0] four_gain_loop_out
);
   reg [2:0] up_q;
   wire live = up_q[2];
   // skip the sync stages and load cycle, where outputs still hold reset values
   always @(posedge clk_sys_in or negedge rstn_in)
      if (!rstn_in) up_q <= 3'h0;
      else if (!live) up_q <= up_q + 3'h1;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!live);
   sequence save_s;
      save_nonvolatile_cmd_in ##1 nv_write_out;
   endsequence
   save_pulse_a: assert property (
      nv_write_out |=> !nv_write_out) else $error("write strobe too long");
   save_data_a: assert property (
      save_nonvolatile_cmd_in |-> save_s ##0 nv_gain_out == $past(gain_setting_out))
      else $error("save lost or wrong");
   set_gain_a: assert property (
      set_prop_gain_cmd_in && !factory_restore_cmd_in |=> gain_setting_out[6:0] ==
      ($past(cmd_gain_in) > 7'h64 ? 7'h64 : $past(cmd_gain_in))) else $error("bad gain");
   set_max_a: assert property (
      set_vel_max_cmd_in && !factory_restore_cmd_in |=>
      gain_max_out[4*MAX_W-1 -: MAX_W] == $past(cmd_max_in)) else $error("bad max");
   fact_gain_a: assert property (
      factory_restore_cmd_in |=> gain_setting_out == {4{`SGPS_FACT_GAIN}})
      else $error("factory gains");
   fact_max_a: assert property (
      factory_restore_cmd_in |=> gain_max_out == {4{`SGPS_FACT_MAX}})
      else $error("factory maximums");
   disp_range_a: assert property (
      display_on_out |-> display_out <= `SGPS_DISP_TOP) else $error("display range");
   loop_scale_a: assert property (
      1'b1 |=> 32'(four_gain_loop_out[MAX_W-1:0]) == 32'($past(gain_setting_out[6:0]))
      * 32'($past(gain_max_out[MAX_W-1:0])) / 32'd100) else $error("scaled gain");
endmodule // sgps_store_checker

// ### tb/sgps_store_tb.sv
// bench for the gain store: panel buttons and serial pulses against an nv model
// assumes a short auto-repeat interval of 8 cycles
module sgps_store_tb;
   timeunit 1ns;
   timeprecision 1ps;
   reg clk_sys_in, rstn_in;
   reg [5:0] btn_q;
   reg [10:0] cmd_q;
   reg [6:0] cmd_gain_in;
   reg [15:0] cmd_max_in;
   wire btn_p_in, btn_i_in, btn_d_in, btn_v_in, btn_up_in, btn_down_in;
   wire soft_reset_cmd_in, factory_restore_cmd_in, save_nonvolatile_cmd_in;
   wire set_prop_gain_cmd_in, set_integ_gain_cmd_in, set_deriv_gain_cmd_in;
   wire set_vel_gain_cmd_in, set_prop_max_cmd_in, set_integ_max_cmd_in;
   wire set_deriv_max_cmd_in, set_vel_max_cmd_in, nv_write_out, display_on_out;
   wire [27:0] nv_gain_in, nv_gain_out, gain_setting_out;
   wire [63:0] nv_max_in, nv_max_out, gain_max_out, four_gain_loop_out;
   wire [6:0] display_out;
   integer mismatches, samples_checked, cycles, i;
   assign {btn_down_in, btn_up_in, btn_v_in, btn_d_in, btn_i_in, btn_p_in} = btn_q;
   assign {set_vel_max_cmd_in, set_deriv_max_cmd_in, set_integ_max_cmd_in,
      set_prop_max_cmd_in, set_vel_gain_cmd_in, set_deriv_gain_cmd_in,
      set_integ_gain_cmd_in, set_prop_gain_cmd_in, save_nonvolatile_cmd_in,
      factory_restore_cmd_in, soft_reset_cmd_in} = cmd_q;
   sgps_store #(.REPEAT_CYC(8)) dut (.*);
   sgps_nv_model nv (.clk_sys_in(clk_sys_in), .nv_write_in(nv_write_out),
      .gain_in(nv_gain_out), .max_in(nv_max_out), .gain_out(nv_gain_in), .max_out(nv_max_in));
   always #5 clk_sys_in = ~clk_sys_in;
   // drives land 1 ns past the edge so no sample races them
   task cyc(input integer n); begin repeat (n) @(posedge clk_sys_in); #1; end endtask
   task pulse(input integer b); begin cmd_q <= 11'h1 << b; cyc(1); cmd_q <= 11'h0; cyc(3); end
   endtask
   // tap up or down while the proportional select stays held
   task tap(input [5:0] b); begin btn_q <= 6'h01 | b; cyc(2); btn_q <= 6'h01; cyc(2); end endtask
   task chk(input logic [63:0] g, input logic [63:0] e); begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   end endtask
   task wrap_up; begin
      $display("compares %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   end endtask
   // hang guard, far above the 166 cycles the sequence needs
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin mismatches = mismatches + 1; wrap_up; end
   end
   initial begin
      clk_sys_in = 0; rstn_in = 0; btn_q = 0; cmd_q = 0; cmd_gain_in = 0; cmd_max_in = 0;
      mismatches = 0; samples_checked = 0; cycles = 0;
      cyc(12); rstn_in <= 1; cyc(8);
      chk(gain_setting_out, {7'h28, 7'h1e, 7'h14, 7'h0a});
      for (i = 0; i < 4; i = i + 1) begin
         cmd_gain_in <= 7'h0b + i; cmd_max_in <= 16'h0300 + i; pulse(3 + i); pulse(7 + i);
         chk(gain_setting_out[7*i +: 7], 7'h0b + i);
         chk(gain_max_out[16*i +: 16], 16'h0300 + i);
      end
      cmd_gain_in <= 7'h7f; pulse(3); chk(gain_setting_out[6:0], 7'h64);
      chk(four_gain_loop_out[15:0], 16'h0300);
      cmd_gain_in <= 7'h61; pulse(3); btn_q <= 6'h01; cyc(3);
      chk(display_out, 7'h61);
      tap(6'h10); tap(6'h10); tap(6'h10); chk(display_out, 7'h63);
      chk(gain_setting_out[6:0], 7'h63);
      btn_q <= 6'h21; cyc(34); btn_q <= 6'h01; cyc(2);
      chk(gain_setting_out[6:0] inside {[7'h5c:7'h5f]}, 1'b1);
      btn_q <= 0; cmd_gain_in <= 7'h00; pulse(3); btn_q <= 6'h01; cyc(3); tap(6'h20);
      chk(gain_setting_out[6:0], 7'h00);
      btn_q <= 6'h0f; cyc(3); btn_q <= 0; cyc(2);
      cmd_gain_in <= 7'h05; pulse(3); pulse(0);
      chk(gain_setting_out, {7'h0e, 7'h0d, 7'h0c, 7'h00});
      btn_q <= 6'h03; cyc(3); btn_q <= 0; cyc(2);
      chk(gain_setting_out, {4{7'h32}});
      chk(gain_max_out, {4{16'h1000}});
      cmd_gain_in <= 7'h07; pulse(3); pulse(1); chk(gain_setting_out, {4{7'h32}});
      pulse(2); pulse(3); rstn_in <= 0; cyc(2); rstn_in <= 1; cyc(8);
      chk(gain_setting_out, {4{7'h32}});
      wrap_up;
   end
endmodule // sgps_store_tb
bind sgps_store sgps_store_checker #(.MAX_W(MAX_W)) chk (.*);
